// ### hw/mmrb_pkg.sv
/*
  Package for the motor measurement readback bank: register addresses,
  field layouts, reset values and gain encodings.
  Assumes a plain address/strobe register port with 32-bit data.
*/
package mmrb_pkg;

  localparam int MMRB_ADDR_W = 12;
  localparam int MMRB_DATA_W = 32;
  localparam int MMRB_GAIN_W = 16;

  // offsets are word indices; byte address is four times these
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_PHASE_B_CURRENT = 12'h440;
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_PHASE_C_CURRENT = 12'h442;
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_CUR_GAIN = 12'h466;
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_VOLT_GAIN = 12'h476;
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_SUPPLY_BUS_V = 12'h478;
  localparam logic [MMRB_ADDR_W-1:0] MMRB_IDX_PHASE_A_V = 12'h47e;

  // gain field position
  localparam int MMRB_GAIN_LSB = 0;
  localparam int MMRB_GAIN_MSB = 15;

  // reset values
  localparam logic [MMRB_DATA_W-1:0] MMRB_RST_WORD = 32'h0000_0000;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_RST_GAIN = 16'h0000;
  localparam logic [MMRB_DATA_W-1:0] MMRB_UNMAPPED = 32'h0000_0000;

  // current sense gain codes, volts per ampere
  localparam logic [MMRB_GAIN_W-1:0] MMRB_CGAIN_1V2 = 16'h0000;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_CGAIN_0V6 = 16'h0001;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_CGAIN_0V3 = 16'h0002;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_CGAIN_0V15 = 16'h0003;

  // voltage sense gain codes, full scale
  localparam logic [MMRB_GAIN_W-1:0] MMRB_VGAIN_60V = 16'h0000;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_VGAIN_30V = 16'h0001;
  localparam logic [MMRB_GAIN_W-1:0] MMRB_VGAIN_15V = 16'h0002;

  // scaling: fraction bits of every measurement word
  localparam int MMRB_FRAC_BITS = 27;

endpackage

// ### hw/mmrb_regs.sv
/*
  Motor measurement readback bank: holds the latest measured currents,
  voltages and sense gain settings and serves them to software.
  Assumes the measurement engine on core_clk presents each value with a
  one-cycle update strobe, and a register master per the plain port.
  Assumes further:
  - every input is already on core_clk, so nothing is synchronised here;
  - reg_addr is a byte address and its two low bits are not decoded;
  - a read strobe is one cycle long and its word stands on reg_rdata in
    the next cycle only, zero otherwise;
  - write strobes may arrive but never reach storage;
  - an update and a read of the same word in one cycle read the old word;
  - the phase A voltage is only taken while startup speed detection runs.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module mmrb_regs
  import mmrb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [MMRB_ADDR_W+1:0] reg_addr,
  input wire logic [MMRB_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MMRB_DATA_W-1:0] reg_rdata,
  // measurement updates
  input wire logic phase_b_current_vld,
  input wire logic [MMRB_DATA_W-1:0] phase_b_current_in,
  input wire logic phase_c_current_vld,
  input wire logic [MMRB_DATA_W-1:0] phase_c_current_in,
  input wire logic current_amp_gain_vld,
  input wire logic [MMRB_GAIN_W-1:0] current_amp_gain_in,
  input wire logic voltage_gain_vld,
  input wire logic [MMRB_GAIN_W-1:0] voltage_gain_in,
  input wire logic supply_bus_volts_vld,
  input wire logic [MMRB_DATA_W-1:0] supply_bus_volts_in,
  input wire logic startup_speed_detection,
  input wire logic terminal_a_volts_vld,
  input wire logic [MMRB_DATA_W-1:0] terminal_a_volts_in
);

  typedef struct packed {
    logic [MMRB_DATA_W-1:0] phase_b_current;
    logic [MMRB_DATA_W-1:0] phase_c_current;
    logic [MMRB_GAIN_W-1:0] current_amp_gain_readback;
    logic [MMRB_GAIN_W-1:0] voltage_gain_readback;
    logic [MMRB_DATA_W-1:0] supply_bus_volts_word;
    logic [MMRB_DATA_W-1:0] terminal_a_volts_word;
    logic [MMRB_DATA_W-1:0] rdata;
  } mmrb_state_t;

  // read selection, one bit per mapped word
  typedef enum logic [6:0] {
    MMRB_SEL_NONE = 7'h01,
    MMRB_SEL_PHASE_B = 7'h02,
    MMRB_SEL_PHASE_C = 7'h04,
    MMRB_SEL_CUR_GAIN = 7'h08,
    MMRB_SEL_VOLT_GAIN = 7'h10,
    MMRB_SEL_SUPPLY = 7'h20,
    MMRB_SEL_PHASE_A = 7'h40
  } mmrb_sel_t;

  mmrb_state_t state;
  mmrb_state_t next_state;
  logic [MMRB_ADDR_W-1:0] read_index;
  mmrb_sel_t read_sel;
  logic phase_a_take;

  ////////////////////////////////////////////////////////////////////////////

  // word index from byte address; low two bits ignored
  function automatic logic [MMRB_ADDR_W-1:0] mmrb_index(
    input logic [MMRB_ADDR_W+1:0] addr
  );
    mmrb_index = addr[MMRB_ADDR_W+1:2];
  endfunction

  // 16-bit field into a word, upper bits zero
  function automatic logic [MMRB_DATA_W-1:0] mmrb_gain_word(
    input logic [MMRB_GAIN_W-1:0] gain
  );
    mmrb_gain_word = MMRB_RST_WORD;
    mmrb_gain_word[MMRB_GAIN_MSB:MMRB_GAIN_LSB] = gain;
  endfunction

  // new word when its strobe is up, else the held one
  function automatic logic [MMRB_DATA_W-1:0] mmrb_take_word(
    input logic vld,
    input logic [MMRB_DATA_W-1:0] held,
    input logic [MMRB_DATA_W-1:0] fresh
  );
    if (vld) begin
      mmrb_take_word = fresh;
    end else begin
      mmrb_take_word = held;
    end
  endfunction

  // same for a 16-bit gain code; codes are kept as given
  function automatic logic [MMRB_GAIN_W-1:0] mmrb_take_gain(
    input logic vld,
    input logic [MMRB_GAIN_W-1:0] held,
    input logic [MMRB_GAIN_W-1:0] fresh
  );
    if (vld) begin
      mmrb_take_gain = fresh;
    end else begin
      mmrb_take_gain = held;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // strobed word index to read selection; others read as zero
  function automatic mmrb_sel_t mmrb_decode(
    input logic rd,
    input logic [MMRB_ADDR_W-1:0] index
  );
    mmrb_decode = MMRB_SEL_NONE;
    if (rd) begin
      unique case (index)
        MMRB_IDX_PHASE_B_CURRENT: begin
          mmrb_decode = MMRB_SEL_PHASE_B;
        end

        MMRB_IDX_PHASE_C_CURRENT: begin
          mmrb_decode = MMRB_SEL_PHASE_C;
        end

        MMRB_IDX_CUR_GAIN: begin
          mmrb_decode = MMRB_SEL_CUR_GAIN;
        end

        MMRB_IDX_VOLT_GAIN: begin
          mmrb_decode = MMRB_SEL_VOLT_GAIN;
        end

        MMRB_IDX_SUPPLY_BUS_V: begin
          mmrb_decode = MMRB_SEL_SUPPLY;
        end

        MMRB_IDX_PHASE_A_V: begin
          mmrb_decode = MMRB_SEL_PHASE_A;
        end

        default: begin
          mmrb_decode = MMRB_SEL_NONE;
        end
      endcase
    end
  endfunction

  // selected held value as a bus word
  function automatic logic [MMRB_DATA_W-1:0] mmrb_read_word(
    input mmrb_sel_t sel,
    input mmrb_state_t held
  );
    unique case (sel)
      MMRB_SEL_PHASE_B: begin
        mmrb_read_word = held.phase_b_current;
      end

      MMRB_SEL_PHASE_C: begin
        mmrb_read_word = held.phase_c_current;
      end

      MMRB_SEL_CUR_GAIN: begin
        mmrb_read_word = mmrb_gain_word(held.current_amp_gain_readback);
      end

      MMRB_SEL_VOLT_GAIN: begin
        mmrb_read_word = mmrb_gain_word(held.voltage_gain_readback);
      end

      MMRB_SEL_SUPPLY: begin
        mmrb_read_word = held.supply_bus_volts_word;
      end

      MMRB_SEL_PHASE_A: begin
        mmrb_read_word = held.terminal_a_volts_word;
      end

      MMRB_SEL_NONE: begin
        mmrb_read_word = MMRB_UNMAPPED;
      end

      default: begin
        mmrb_read_word = MMRB_UNMAPPED;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign read_index = mmrb_index(reg_addr);

  // no strobe selects nothing, so rdata falls back to zero
  assign read_sel = mmrb_decode(reg_rd, read_index);

  // phase A voltage only taken while startup detection runs
  assign phase_a_take = terminal_a_volts_vld && startup_speed_detection;

  always_comb begin
    next_state = state;
    // capture measurements; reg_wr and reg_wdata never reach storage

    next_state.phase_b_current = mmrb_take_word(
      phase_b_current_vld,
      state.phase_b_current,
      phase_b_current_in
    );

    next_state.phase_c_current = mmrb_take_word(
      phase_c_current_vld,
      state.phase_c_current,
      phase_c_current_in
    );

    next_state.current_amp_gain_readback = mmrb_take_gain(
      current_amp_gain_vld,
      state.current_amp_gain_readback,
      current_amp_gain_in
    );

    next_state.voltage_gain_readback = mmrb_take_gain(
      voltage_gain_vld,
      state.voltage_gain_readback,
      voltage_gain_in
    );

    next_state.supply_bus_volts_word = mmrb_take_word(
      supply_bus_volts_vld,
      state.supply_bus_volts_word,
      supply_bus_volts_in
    );

    next_state.terminal_a_volts_word = mmrb_take_word(
      phase_a_take,
      state.terminal_a_volts_word,
      terminal_a_volts_in
    );

    // read data stands only in the cycle after the strobe
    next_state.rdata = mmrb_read_word(read_sel, state);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state.phase_b_current <= MMRB_RST_WORD;
      state.phase_c_current <= MMRB_RST_WORD;
      state.current_amp_gain_readback <= MMRB_RST_GAIN;
      state.voltage_gain_readback <= MMRB_RST_GAIN;
      state.supply_bus_volts_word <= MMRB_RST_WORD;
      state.terminal_a_volts_word <= MMRB_RST_WORD;
      state.rdata <= MMRB_UNMAPPED;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;

endmodule // mmrb_regs

`default_nettype wire

// ### test/mmrb_checker.sv
/* checker for the readback bank: read timing, values, ignored writes.
   assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module mmrb_checker
  import mmrb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [MMRB_ADDR_W+1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [MMRB_DATA_W-1:0] reg_rdata,
  // updates
  input wire logic phase_b_current_vld,
  input wire logic [MMRB_DATA_W-1:0] phase_b_current_in,
  input wire logic phase_c_current_vld,
  input wire logic [MMRB_DATA_W-1:0] phase_c_current_in,
  input wire logic supply_bus_volts_vld,
  input wire logic [MMRB_DATA_W-1:0] supply_bus_volts_in,
  input wire logic startup_speed_detection,
  input wire logic terminal_a_volts_vld,
  input wire logic [MMRB_DATA_W-1:0] terminal_a_volts_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic [MMRB_ADDR_W-1:0] ix = reg_addr[MMRB_ADDR_W+1:2];
  ////////////////////////////////////////////////////////////////////////
  chk_data_after_read: assert property (
    reg_rdata != '0 |-> $past(reg_rd)) else $error("data without read");
  chk_cgain_upper: assert property (
    reg_rd && ix == MMRB_IDX_CUR_GAIN |=> reg_rdata[31:16] == 16'h0000)
    else $error("current gain upper bits set");
  chk_vgain_upper: assert property (
    reg_rd && ix == MMRB_IDX_VOLT_GAIN |=> reg_rdata[31:16] == 16'h0000)
    else $error("voltage gain upper bits set");
  chk_phase_b_word: assert property (
    phase_b_current_vld ##1 reg_rd && ix == MMRB_IDX_PHASE_B_CURRENT
    && !phase_b_current_vld |=> reg_rdata == $past(phase_b_current_in, 2))
    else $error("phase b word wrong");
  chk_phase_c_word: assert property (
    phase_c_current_vld ##1 reg_rd && ix == MMRB_IDX_PHASE_C_CURRENT
    && !phase_c_current_vld |=> reg_rdata == $past(phase_c_current_in, 2))
    else $error("phase c word wrong");
  chk_supply_word: assert property (
    supply_bus_volts_vld ##1 reg_rd && ix == MMRB_IDX_SUPPLY_BUS_V
    && !supply_bus_volts_vld |=> reg_rdata == $past(supply_bus_volts_in, 2))
    else $error("supply word wrong");
  chk_phase_a_word: assert property (
    terminal_a_volts_vld && startup_speed_detection ##1 reg_rd
    && ix == MMRB_IDX_PHASE_A_V && !terminal_a_volts_vld
    |=> reg_rdata == $past(terminal_a_volts_in, 2)) else $error("phase a bad");
  chk_write_ignored: assert property (
    reg_rd && ix == MMRB_IDX_PHASE_C_CURRENT && !phase_c_current_vld
    ##1 reg_wr && !phase_c_current_vld ##1 reg_rd && !phase_c_current_vld
    && ix == MMRB_IDX_PHASE_C_CURRENT |=> reg_rdata == $past(reg_rdata, 2))
    else $error("write changed phase c");
  cover property (reg_wr ##1 reg_rd);
  cover property (terminal_a_volts_vld && !startup_speed_detection);
  cover property (phase_b_current_vld ##1 reg_rd);
endmodule // mmrb_checker
`default_nettype wire

// ### test/mmrb_regs_tb_top.sv
/* bench for the readback bank: random updates, reads and writes.
   assumes the package and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module mmrb_regs_tb_top
  import mmrb_pkg::*;
;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic startup_speed_detection = 0;
  logic [13:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, v = '0, seed = 32'h50;
  wire logic [31:0] reg_rdata;
  logic [31:0] ex [6];
  logic [11:0] ix [6] = '{MMRB_IDX_PHASE_B_CURRENT, MMRB_IDX_PHASE_C_CURRENT,
    MMRB_IDX_CUR_GAIN, MMRB_IDX_VOLT_GAIN, MMRB_IDX_SUPPLY_BUS_V,
    MMRB_IDX_PHASE_A_V};
  logic [5:0] vld = '0;
  int err_total = 0, n_compared = 0, r;
  wire logic phase_b_current_vld = vld[0], phase_c_current_vld = vld[1];
  wire logic current_amp_gain_vld = vld[2], voltage_gain_vld = vld[3];
  wire logic supply_bus_volts_vld = vld[4], terminal_a_volts_vld = vld[5];
  wire logic [31:0] phase_b_current_in = v, phase_c_current_in = v;
  wire logic [31:0] supply_bus_volts_in = v, terminal_a_volts_in = v;
  wire logic [15:0] current_amp_gain_in = v[15:0], voltage_gain_in = v[15:0];
  mmrb_regs DUT (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .phase_b_current_vld(phase_b_current_vld),
    .phase_b_current_in(phase_b_current_in),
    .phase_c_current_vld(phase_c_current_vld),
    .phase_c_current_in(phase_c_current_in),
    .current_amp_gain_vld(current_amp_gain_vld),
    .current_amp_gain_in(current_amp_gain_in),
    .voltage_gain_vld(voltage_gain_vld),
    .voltage_gain_in(voltage_gain_in),
    .supply_bus_volts_vld(supply_bus_volts_vld),
    .supply_bus_volts_in(supply_bus_volts_in),
    .startup_speed_detection(startup_speed_detection),
    .terminal_a_volts_vld(terminal_a_volts_vld),
    .terminal_a_volts_in(terminal_a_volts_in)
  );
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // gain words carry only their 16-bit code, upper half zero
  function automatic logic [31:0] exp_word(int k, logic [31:0] d);
    if (k == 2 || k == 3) return {16'h0000, d[15:0]};
    return d;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic op(logic rd, logic wr, logic [11:0] i);
    @(posedge core_clk);
    reg_rd <= rd;
    reg_wr <= wr;
    reg_addr <= {i, 2'b00};
    reg_wdata <= rnd();
    vld <= '0;
  endtask
  task automatic cmp(logic [31:0] e, logic [11:0] i);
    n_compared++;
    if (reg_rdata !== e) begin
      err_total++;
      $display("MISMATCH reg %h exp %h got %h", i, e, reg_rdata);
    end
  endtask
  task automatic rdc(int k);
    op(1, 0, ix[k]);
    op(0, 0, 12'h000);
    #1 cmp(ex[k], ix[k]);
  endtask
  task automatic put(int k, logic [31:0] d, logic s);
    @(posedge core_clk);
    v <= d;
    startup_speed_detection <= s;
    vld <= 6'(1 << k);
    if (k != 5 || s) ex[k] = exp_word(k, d);
  endtask
  task automatic rst_chk(int n);
    rst <= 1;
    ex = '{default: '0};
    repeat (n) @(posedge core_clk);
    rst <= 0;
    for (int k = 0; k < 6; k++) rdc(k);
  endtask
  initial begin
    rst_chk(3);
    op(1, 0, 12'h441);
    op(0, 0, 12'h000);
    #1 cmp('0, 12'h441);
    for (int c = 0; c < 4; c++) begin
      put(2, c, 0);
      rdc(2);
      put(3, c % 3, 0);
      rdc(3);
    end
    put(1, rnd(), 0);
    op(1, 0, ix[1]);
    op(0, 1, ix[1]);
    #1 cmp(ex[1], ix[1]);
    rdc(1);
    repeat (300) begin
      r = rnd() % 6;
      put(r, rnd(), rnd() % 2);
      if (rnd() % 2) op(0, 1, ix[r]);
      rdc(r);
    end
    @(posedge core_clk);
    rst_chk(1);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
endmodule // mmrb_regs_tb_top
bind mmrb_regs mmrb_checker chk (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .phase_b_current_vld(phase_b_current_vld),
  .phase_b_current_in(phase_b_current_in),
  .phase_c_current_vld(phase_c_current_vld),
  .phase_c_current_in(phase_c_current_in),
  .supply_bus_volts_vld(supply_bus_volts_vld),
  .supply_bus_volts_in(supply_bus_volts_in),
  .startup_speed_detection(startup_speed_detection),
  .terminal_a_volts_vld(terminal_a_volts_vld),
  .terminal_a_volts_in(terminal_a_volts_in)
);
`default_nettype wire
